// ### pkg/ssr_pkg.sv
// package for the start-stop five-unit receiver: constants, modes and state carriers
`default_nettype none
package ssr_pkg;
   // ==========================================================
   // timing
   localparam int unsigned SSR_CLK_HZ = 100_000_000;
   localparam int unsigned SSR_SLOT_MS = 22;
   // cycles per impulse slot, 22 ms at 100 MHz
   localparam int unsigned SSR_SLOT_CYC = SSR_SLOT_MS * (SSR_CLK_HZ / 1000);
   localparam int unsigned SSR_CODE_BITS = 5;
   localparam int unsigned SSR_CNT_W = 22;
   localparam int unsigned SSR_OFS_W = 8;
   // sampling point sits at the middle of the slot by default
   localparam logic [SSR_OFS_W-1:0] SSR_OFS_MID = 8'h80;
   // ==========================================================
   // reset values and bit index limits
   localparam logic [SSR_CODE_BITS-1:0] SSR_CHAR_RST = 5'h00;
   localparam logic [SSR_CNT_W-1:0] SSR_CNT_RST = 22'h000000;
   localparam logic [2:0] SSR_IDX_RST = 3'h0;
   localparam logic [2:0] SSR_IDX_LAST = 3'h4;
   localparam logic [2:0] SSR_IDX_STOP = 3'h5;
   // ==========================================================
   // line modes and cycle states
   typedef enum logic {
      SSR_MODE_NEUTRAL,
      SSR_MODE_POLAR
   } ssr_mode_type;
   typedef enum logic [1:0] {
      SSR_ST_STOPPED,
      SSR_ST_START,
      SSR_ST_CODE,
      SSR_ST_STOP
   } ssr_state_type;
   // line sense inputs grouped
   typedef struct packed {
      logic current;
      logic reversed;
   } ssr_line_type;
   // receiver state
   typedef struct packed {
      ssr_state_type state;
      logic [SSR_CNT_W-1:0] cnt;
      logic [2:0] idx;
      logic [SSR_CODE_BITS-1:0] chr;
      logic done;
      logic busy;
   } ssr_rx_type;
endpackage : ssr_pkg
`default_nettype wire

// ### logic/ssr_line_decode.sv
// line decoder: synchronises the line pins and turns them into a mark level
`timescale 1ns/100ps
`default_nettype none
module ssr_line_decode
   import ssr_pkg::*;
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // line pins and mode
   input wire ssr_line_type line_in,
   input wire ssr_mode_type mode,
   // decoded level
   output logic mark
);
   // ==========================================================
   // two-stage synchroniser, stage one feeds stage two only
   typedef struct packed {
      ssr_line_type s1;
      ssr_line_type s2;
   } ssr_sync_type;
   ssr_sync_type sync_r;
   ssr_sync_type sync_nxt;
   // idle line carries current, so reset to marking
   always_comb begin
      sync_nxt.s1 = line_in;
      sync_nxt.s2 = sync_r.s1;
   end
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         sync_r <= '{s1: '{current: 1'b1, reversed: 1'b0}, s2: '{current: 1'b1, reversed: 1'b0}};
      end else begin
         sync_r <= sync_nxt;
      end
   end
   // polar: mark is current not reversed; neutral: mark is current present
   always_comb begin
      if (mode == SSR_MODE_POLAR) begin
         mark = sync_r.s2.current & ~sync_r.s2.reversed; // [R10]
      end else begin
         mark = sync_r.s2.current; // [R11]
      end
   end
   // ==========================================================
   // assertions: decoded level against the pins two edges back
   a_polar_decode: assert property (@(posedge clock) disable iff (!rst_n) // [R10]
      $past(rst_n) && $past(rst_n, 2) && mode == SSR_MODE_POLAR
      |-> mark == ($past(line_in.current, 2) & ~$past(line_in.reversed, 2)))
      else $error("polar line level decoded wrongly");
   a_neutral_decode: assert property (@(posedge clock) disable iff (!rst_n) // [R11]
      $past(rst_n) && $past(rst_n, 2) && mode == SSR_MODE_NEUTRAL
      |-> mark == $past(line_in.current, 2))
      else $error("neutral line level decoded wrongly");
endmodule : ssr_line_decode
`default_nettype wire

// ### logic/ssr_receiver.sv
// start-stop five-unit receiver: character cycle timing and code sampling
//
// Summary of operation
// R1: while the line is marking the receiver stays stopped.
// R2: a spacing start impulse immediately begins one timed character cycle.
// R3: sender frames start, five code impulses, then stop with no gap.
// R4: five code impulses are sampled in their own slots into matching bits.
// R5: marking sample stores one, spacing sample stores zero.
// R6: stored bits hold until a later cycle overwrites them.
// R7: all bits fall in one fixed cycle; the stop impulse ends it.
// R8: marking stop impulse re-arms, so one cycle covers exactly one character.
// R9: after the cycle, wait stopped for the next start impulse.
// R10: polar mode decodes mark and space by current polarity.
// R11: neutral mode decodes current present as mark, absent as space.
// R12: slot is 22 ms; sampling point inside it is adjustable.
// R13: flag character complete after fifth bit, before the stop impulse.
// R14: slots counted on system clock; reset gives stopped, bits cleared.
//
// timing notes
// the line pins pass a two-stage synchroniser, so every level the
// cycle logic sees is two clocks behind the pins; the start slot is
// timed from the decoded edge, which shifts every slot by the same two
// clocks and so keeps the sampling points where the setting puts them.
// the start slot is not resampled: a short spacing glitch on an idle
// line still releases a full character cycle, the price of starting at
// once on the first spacing level.
// the stop impulse is not timed; the cycle closes on the first marking
// level in the stop state, so a long stop only stretches the wait and
// a following start can be taken on the next clock.
// no framing error is reported; a missing stop simply holds busy high
// until the line returns to marking.
// the sampling point is slot length times the setting over 256; the
// middle setting gives half a slot, the widest lead and lag margin.
// settings are static: changing mode or offset inside a cycle gives
// an undefined sample for the slot in flight.
// the character output keeps its bits between cycles and is rewritten
// bit by bit during the next cycle, so a consumer must take it on the
// one-cycle complete flag, before the first code sample of the next cycle overwrites bit 0.
//
`timescale 1ns/100ps
`default_nettype none
module ssr_receiver
   import ssr_pkg::*;
#(
   parameter int unsigned SLOT_CYC = SSR_SLOT_CYC
)
(
   // clock and reset
   input wire logic clock,
   input wire logic rst_n,
   // line pins
   input wire ssr_line_type line_in,
   // settings, held static while receiving
   input wire ssr_mode_type mode,
   input wire logic [SSR_OFS_W-1:0] sample_ofs,
   // received character
   output logic [SSR_CODE_BITS-1:0] char_out,
   output logic char_done,
   output logic busy
);
   // ==========================================================
   // line decode
   logic mark;
   ssr_line_decode u_dec (
      .clock(clock),
      .rst_n(rst_n),
      .line_in(line_in),
      .mode(mode),
      .mark(mark)
   );
   // ==========================================================
   // sampling point within a slot, scaled from the setting
   localparam logic [SSR_CNT_W-1:0] SLOT_LAST = SSR_CNT_W'(SLOT_CYC - 1);
   logic [SSR_CNT_W+SSR_OFS_W-1:0] prod;
   logic [SSR_CNT_W-1:0] samp_pt;
   // the product is wide so that no setting overflows; low bits dropped by shift
   always_comb begin
      prod = (SSR_CNT_W+SSR_OFS_W)'(SLOT_CYC) * (SSR_CNT_W+SSR_OFS_W)'(sample_ofs);
      samp_pt = prod[SSR_CNT_W+SSR_OFS_W-1:SSR_OFS_W]; // [R12]
   end
   // ==========================================================
   // state
   ssr_rx_type rx_r;
   ssr_rx_type rx_nxt;
   logic slot_end;
   logic at_samp;
   assign slot_end = (rx_r.cnt == SLOT_LAST);
   assign at_samp = (rx_r.cnt == samp_pt);
   // next-state logic of the character cycle
   always_comb begin
      rx_nxt = rx_r;
      rx_nxt.done = 1'b0;
      rx_nxt.cnt = slot_end ? SSR_CNT_RST : rx_r.cnt + 1'b1; // [R14]
      unique case (rx_r.state)
         SSR_ST_STOPPED: begin
            rx_nxt.cnt = SSR_CNT_RST;
            rx_nxt.busy = 1'b0;
            // idle marking line keeps the cycle locked
            if (!mark) begin // [R1] [R2] [R9]
               rx_nxt.state = SSR_ST_START;
               rx_nxt.busy = 1'b1;
               rx_nxt.idx = SSR_IDX_RST;
            end
         end
         SSR_ST_START: begin
            // start slot is timed from its own edge, no resampling of the start
            if (slot_end) begin
               rx_nxt.state = SSR_ST_CODE;
            end
         end
         SSR_ST_CODE: begin
            if (at_samp) begin
               rx_nxt.chr[rx_r.idx] = mark; // [R4] [R5]
               if (rx_r.idx == SSR_IDX_LAST) begin
                  rx_nxt.done = 1'b1; // [R13]
               end
            end
            if (slot_end) begin
               if (rx_r.idx == SSR_IDX_LAST) begin
                  rx_nxt.state = SSR_ST_STOP; // [R7]
               end
               rx_nxt.idx = rx_r.idx + 1'b1;
            end
         end
         SSR_ST_STOP: begin
            // wait for the marking stop level; a late stop only stretches the wait
            if (mark) begin // [R8] [R7]
               rx_nxt.state = SSR_ST_STOPPED;
               rx_nxt.busy = 1'b0;
               rx_nxt.cnt = SSR_CNT_RST;
            end
         end
      endcase
   end
   // register the state; reset clears the character
   always_ff @(posedge clock) begin
      if (!rst_n) begin
         rx_r <= '{state: SSR_ST_STOPPED, cnt: SSR_CNT_RST, idx: SSR_IDX_RST,
                   chr: SSR_CHAR_RST, done: 1'b0, busy: 1'b0}; // [R14]
      end else begin
         rx_r <= rx_nxt;
      end
   end
   // outputs straight from flip-flops; char holds between cycles
   assign char_out = rx_r.chr; // [R6]
   assign char_done = rx_r.done;
   assign busy = rx_r.busy;
   // ==========================================================
   // assertions
   sequence s_start_seen;
      rx_r.state == SSR_ST_STOPPED && !mark;
   endsequence
   sequence s_char_flag;
      rx_r.state == SSR_ST_CODE && at_samp && rx_r.idx == SSR_IDX_LAST;
   endsequence
   a_idle_stays_stopped: assert property (@(posedge clock) disable iff (!rst_n) // [R1]
      rx_r.state == SSR_ST_STOPPED && mark |=> rx_r.state == SSR_ST_STOPPED)
      else $error("receiver left stopped state on marking line");
   a_start_begins_cycle: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
      s_start_seen |=> rx_r.state == SSR_ST_START && rx_r.cnt == SSR_CNT_RST && busy)
      else $error("start impulse did not begin a cycle");
   a_bit_sampled: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
      rx_r.state == SSR_ST_CODE && at_samp |=> char_out[$past(rx_r.idx)] == $past(mark))
      else $error("code bit not stored from line");
   a_bits_hold: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
      rx_r.state != SSR_ST_CODE |=> $stable(char_out))
      else $error("character changed outside code slots");
   a_done_flag: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
      s_char_flag |=> char_done ##1 !char_done)
      else $error("character complete flag wrong");
   a_done_only_last: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
      char_done |-> $past(rx_r.idx) == SSR_IDX_LAST && $past(rx_r.state) == SSR_ST_CODE)
      else $error("complete flag before fifth bit");
   a_five_then_stop: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
      rx_r.state == SSR_ST_CODE && slot_end && rx_r.idx == SSR_IDX_LAST
      |=> rx_r.state == SSR_ST_STOP)
      else $error("cycle did not reach stop after five bits");
   a_stop_rearms: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
      rx_r.state == SSR_ST_STOP && mark |=> rx_r.state == SSR_ST_STOPPED && !busy)
      else $error("stop impulse did not re-arm");
   a_idx_bounded: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
      rx_r.state == SSR_ST_CODE |-> rx_r.idx <= SSR_IDX_LAST)
      else $error("bit index out of range");
   a_reset_clears: assert property (@(posedge clock) // [R14]
      !rst_n |=> rx_r.state == SSR_ST_STOPPED && char_out == SSR_CHAR_RST)
      else $error("reset did not clear receiver");
   // ==========================================================
   // slot counter and cycle shape

   // a timed slot still running
   sequence s_slot_run;
      (rx_r.state == SSR_ST_START || rx_r.state == SSR_ST_CODE) && !slot_end;
   endsequence

   // a timed slot at its last count
   sequence s_slot_wrap;
      (rx_r.state == SSR_ST_START || rx_r.state == SSR_ST_CODE) && slot_end;
   endsequence

   // stop state still seeing spacing
   sequence s_stop_wait;
      rx_r.state == SSR_ST_STOP && !mark;
   endsequence

   // end of the fifth code slot
   sequence s_last_wrap;
      rx_r.state == SSR_ST_CODE && slot_end && rx_r.idx == SSR_IDX_LAST;
   endsequence

   // counter never leaves the slot range
   a_cnt_in_slot: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
      rx_r.cnt <= SLOT_LAST)
      else $error("slot counter out of range");

   // a stopped receiver keeps its counter cleared
   a_stopped_cnt_clear: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
      rx_r.state == SSR_ST_STOPPED |-> rx_r.cnt == SSR_CNT_RST)
      else $error("counter running while stopped");

   // counter steps by one inside a slot
   a_cnt_steps: assert property (@(posedge clock) disable iff (!rst_n) // [R14]
      s_slot_run |=> rx_r.cnt == $past(rx_r.cnt) + 1'b1)
      else $error("slot counter skipped");

   // counter restarts at each slot boundary
   a_cnt_wraps: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
      s_slot_wrap |=> rx_r.cnt == SSR_CNT_RST)
      else $error("slot counter did not wrap");

   // start slot runs its full length whatever the line does
   a_start_len: assert property (@(posedge clock) disable iff (!rst_n) // [R2]
      rx_r.state == SSR_ST_START && !slot_end |=> rx_r.state == SSR_ST_START)
      else $error("start slot cut short");

   // start slot hands over to the first code slot
   a_start_to_code: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
      rx_r.state == SSR_ST_START && slot_end
      |=> rx_r.state == SSR_ST_CODE && rx_r.idx == SSR_IDX_RST)
      else $error("start slot did not lead to first code slot");

   // each code slot but the last moves on to the next bit
   a_idx_step: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
      rx_r.state == SSR_ST_CODE && slot_end && rx_r.idx != SSR_IDX_LAST
      |=> rx_r.state == SSR_ST_CODE && rx_r.idx == $past(rx_r.idx) + 1'b1)
      else $error("code slot index did not advance");

   // a fresh cycle always starts from bit 0
   a_start_idx_clear: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
      rx_r.state == SSR_ST_START |-> rx_r.idx == SSR_IDX_RST)
      else $error("start slot with stale bit index");

   // the stop state is only reached past the fifth bit
   a_stop_idx_end: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
      rx_r.state == SSR_ST_STOP |-> rx_r.idx == SSR_IDX_STOP)
      else $error("stop state before five bits");

   // the last code slot leaves the index past the end
   a_last_wrap_idx: assert property (@(posedge clock) disable iff (!rst_n) // [R7]
      s_last_wrap |=> rx_r.idx == SSR_IDX_STOP)
      else $error("index not parked after fifth bit");

   // busy is high exactly while a cycle is open
   a_busy_matches_state: assert property (@(posedge clock) disable iff (!rst_n) // [R2] [R8]
      busy == (rx_r.state != SSR_ST_STOPPED))
      else $error("busy disagrees with cycle state");

   // spacing after the fifth slot keeps the cycle open
   a_stop_waits: assert property (@(posedge clock) disable iff (!rst_n) // [R8]
      s_stop_wait |=> rx_r.state == SSR_ST_STOP && busy)
      else $error("cycle closed without a marking stop");

   // ==========================================================
   // sampling and completion

   // complete flag lasts one clock
   a_done_single: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
      char_done |=> !char_done)
      else $error("complete flag longer than one clock");

   // complete flag only inside an open cycle
   a_done_in_cycle: assert property (@(posedge clock) disable iff (!rst_n) // [R13]
      char_done |-> (rx_r.state == SSR_ST_CODE || rx_r.state == SSR_ST_STOP))
      else $error("complete flag outside a cycle");

   // a stopped receiver never flags a character
   a_stopped_no_done: assert property (@(posedge clock) disable iff (!rst_n) // [R9]
      rx_r.state == SSR_ST_STOPPED |-> !char_done)
      else $error("complete flag while stopped");

   // the fifth bit carries the level seen at its sampling point
   a_done_last_value: assert property (@(posedge clock) disable iff (!rst_n) // [R5]
      char_done |-> char_out[SSR_IDX_LAST] == $past(mark))
      else $error("fifth bit not taken from line");

   // sampling point stays inside the slot
   a_samp_in_slot: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
      samp_pt <= SLOT_LAST)
      else $error("sampling point beyond slot");

   // middle setting samples at half a slot
   a_samp_mid: assert property (@(posedge clock) disable iff (!rst_n) // [R12]
      sample_ofs == SSR_OFS_MID |-> samp_pt == SSR_CNT_W'(SLOT_CYC / 2))
      else $error("middle setting off centre");

   // away from the sampling point the character holds
   a_code_hold_off_pt: assert property (@(posedge clock) disable iff (!rst_n) // [R6]
      rx_r.state == SSR_ST_CODE && !at_samp |=> $stable(char_out))
      else $error("character changed off the sampling point");

   // a sample touches only its own bit
   a_one_bit_written: assert property (@(posedge clock) disable iff (!rst_n) // [R4]
      rx_r.state == SSR_ST_CODE && at_samp
      |=> ((char_out ^ $past(char_out)) & ~(SSR_CODE_BITS'(1) << $past(rx_r.idx))) == '0)
      else $error("sample disturbed another bit");
endmodule : ssr_receiver
`default_nettype wire

// ### sim/ssr_tx_model.sv
// far-side start-stop transmitter model driving the line pins
`timescale 1ns/100ps
`default_nettype none
module ssr_tx_model
   import ssr_pkg::*;
#(
   parameter int unsigned SLOT_CYC = 20
)
(
   // clock and line mode
   input wire logic clock,
   input wire ssr_mode_type mode,
   // line pins
   output var ssr_line_type line_out
);
   // ==========================================================
   // line level: idle is marking current
   initial begin
      line_out = '{current: 1'b1, reversed: 1'b0};
   end
   // neutral mode leaves polarity meaningless, so it is scrambled
   task automatic put(input logic m);
      line_out.current = (mode == SSR_MODE_POLAR) ? 1'b1 : m;
      line_out.reversed = (mode == SSR_MODE_POLAR) ? ~m : 1'($urandom);
   endtask : put
   // park the line at plain marking with polarity clear, so a mode change sees no false start
   task automatic park();
      line_out = '{current: 1'b1, reversed: 1'b0};
   endtask : park
   // one frame: start, five code slots bit0 first, stop, no gaps
   task automatic send(input logic [4:0] ch);
      int i;
      put(1'b0);
      repeat (SLOT_CYC) @(negedge clock);
      for (i = 0; i < 5; i++) begin
         put(ch[i]);
         repeat (SLOT_CYC) @(negedge clock);
      end
      put(1'b1);
      repeat (SLOT_CYC) @(negedge clock);
   endtask : send
endmodule : ssr_tx_model
`default_nettype wire

// ### sim/test_ssr_receiver.sv
// self-checking bench for the start-stop five-unit receiver
`timescale 1ns/100ps
`default_nettype none
module test_ssr_receiver;
   import ssr_pkg::*;
   localparam int unsigned SLOT = 20;
   logic clock = 1'b0;
   logic rst_n = 1'b0;
   ssr_mode_type mode = SSR_MODE_NEUTRAL;
   logic [SSR_OFS_W-1:0] sample_ofs = SSR_OFS_MID;
   ssr_line_type line_in;
   logic [SSR_CODE_BITS-1:0] char_out;
   logic char_done;
   logic busy;
   int mismatches = 0;
   int n_checks = 0;
   int n_done = 0;
   int n_sent = 0;
   logic [SSR_CODE_BITS-1:0] exp_q[$];
   logic [SSR_CODE_BITS-1:0] c;
   // ==========================================================
   // clock, design and far side
   initial begin
      forever #5 clock = ~clock;
   end
   ssr_receiver #(.SLOT_CYC(SLOT)) uut (.clock(clock), .rst_n(rst_n), .line_in(line_in),
      .mode(mode), .sample_ofs(sample_ofs), .char_out(char_out), .char_done(char_done),
      .busy(busy));
   ssr_tx_model #(.SLOT_CYC(SLOT)) tx (.clock(clock), .mode(mode), .line_out(line_in));
   // ==========================================================
   // compares and verdict
   task automatic chk_chr(input string what, input logic [4:0] e, input logic [4:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, e, g);
      end
   endtask : chk_chr
   task automatic chk_flag(input string what, input logic e, input logic g);
      chk_chr(what, {4'h0, e}, {4'h0, g});
   endtask : chk_flag
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : give_verdict
   // each completed character is matched against the model queue
   always @(negedge clock) begin
      if (rst_n && char_done === 1'b1) begin
         n_done++;
         chk_flag("busy at done", 1'b1, busy);
         chk_chr("char", exp_q.pop_front(), char_out);
      end
   end
   // one frame, with busy expected a few cycles after the start edge
   task automatic frame(input logic [4:0] ch);
      exp_q.push_back(ch);
      n_sent++;
      fork
         tx.send(ch);
         begin
            repeat (4) @(negedge clock);
            chk_flag("busy after start", 1'b1, busy);
         end
      join
   endtask : frame
   // ==========================================================
   // tests
   initial begin
      int i;
      void'($urandom(48));
      repeat (16) @(negedge clock);
      rst_n = 1'b1;
      chk_chr("char after reset", SSR_CHAR_RST, char_out);
      repeat (50) @(negedge clock);
      chk_flag("busy idle", 1'b0, busy);
      $display("test reset_idle done");
      // back-to-back frames; offset kept early enough to absorb sync lag
      for (i = 0; i < 12; i++) begin
         if (i == 6) begin
            tx.park();
            repeat (4) @(negedge clock);
            mode = SSR_MODE_POLAR;
            repeat (4) @(negedge clock);
         end
         sample_ofs = 8'($urandom_range(0, 160));
         c = (i == 0) ? 5'h00 : (i == 1) ? 5'h1F : 5'($urandom);
         frame(c);
      end
      repeat (40) @(negedge clock);
      chk_flag("one done per frame", 1'b1, n_done == n_sent);
      chk_flag("busy after stop", 1'b0, busy);
      chk_chr("held char", c, char_out);
      $display("test frames done");
      rst_n = 1'b0;
      repeat (3) @(negedge clock);
      rst_n = 1'b1;
      chk_chr("char after second reset", SSR_CHAR_RST, char_out);
      $display("test second_reset done");
      give_verdict();
   end
   // watchdog well beyond twelve frames
   initial begin
      repeat (20000) @(posedge clock);
      mismatches++;
      give_verdict();
   end
endmodule : test_ssr_receiver
`default_nettype wire
